// ### core/pegp_pkg.sv
// Purpose: Shared constants and types for the port E general I/O block.
// Assumes: 32-bit APB with 12-bit byte addresses, one register per word.
// Notes:   Every offset, field position and reset value lives here.
package pegp_pkg;

    localparam int            PEGP_WIDTH       = 8;
    localparam int            PEGP_ADDR_W      = 12;

    // Register byte addresses.
    localparam logic [11:0]   PEGP_OFS_DIR     = 12'h000;
    localparam logic [11:0]   PEGP_OFS_OUT     = 12'h004;
    localparam logic [11:0]   PEGP_OFS_CFG     = 12'h008;
    localparam logic [11:0]   PEGP_OFS_STAT    = 12'h00C;

    // Reset values.
    localparam logic [7:0]    PEGP_DIR_RST     = 8'h00;
    localparam logic [7:0]    PEGP_OUT_RST     = 8'h00;
    localparam logic [8:0]    PEGP_CFG_RST     = 9'h100;

    // Field positions of the bit 7 timer configuration register.
    localparam int            PEGP_CFG_LANE0_MSB = 7;
    localparam int            PEGP_CFG_DIS_BIT   = 8;

    // Field positions of the status register.
    localparam int            PEGP_STAT_PIN_LSB = 0;
    localparam int            PEGP_STAT_OWN_LSB = 8;

    // Byte lanes of pstrb.
    localparam int            PEGP_LANE0       = 0;
    localparam int            PEGP_LANE1       = 1;

    // Timer encodings that decide whether bit 7 goes to the timer.
    localparam logic [1:0]    PEGP_CMD_NONE    = 2'h0;
    localparam logic [3:0]    PEGP_IOD_MASK_A  = 4'hE;
    localparam logic [3:0]    PEGP_IOD_OUT_A   = 4'hA;
    localparam logic [3:0]    PEGP_IOD_OUT_B   = 4'h9;

    typedef struct packed {
        logic       timer_d3_output_disable;
        logic [1:0] combination_mode_select;
        logic       pwm_mode_three;
        logic       d1_pwm_output_select;
        logic [3:0] d_io_control_field;
    } pegp_bit7_cfg_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe_n;
    } pegp_pin_drive_t;

    typedef enum logic {
        PEGP_ST_IDLE = 1'b0,
        PEGP_ST_RESP = 1'b1
    } pegp_apb_state_t;

endpackage

// ### core/pegp_bit7_sel.sv
// Purpose: Decides whether port E bit 7 is owned by the timer D3 output.
// Assumes: Configuration comes from registers on the same clock.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pegp_bit7_sel
    import pegp_pkg::*;
(
    input  pegp_bit7_cfg_t cfg,
    output logic           timer_owns
);

    always_comb begin
        timer_owns = 1'b0;
        if (!cfg.timer_d3_output_disable) begin
            if (cfg.combination_mode_select != PEGP_CMD_NONE) begin
                timer_owns = 1'b1;
            end else if (cfg.pwm_mode_three) begin
                if (cfg.d1_pwm_output_select) begin
                    timer_owns = 1'b1;
                end else if ((cfg.d_io_control_field & PEGP_IOD_MASK_A) == PEGP_IOD_OUT_A) begin
                    timer_owns = 1'b1;
                end else if (cfg.d_io_control_field == PEGP_IOD_OUT_B) begin
                    timer_owns = 1'b1;
                end
            end
        end
    end

endmodule

// ### core/pegp_top.sv
// Purpose: Eight-bit port E general I/O with timer pin sharing, APB slave.
// Assumes: Pins are asynchronous; timer signals share pclk.
// Notes:   Every access phase lasts two cycles; pready comes from a flop.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pegp_top
    import pegp_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,

    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [PEGP_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,

    input  wire logic [PEGP_WIDTH-1:0]  pin_in,
    output pegp_pin_drive_t             pin_drive,

    input  wire logic [PEGP_WIDTH-1:0]  timer_out,
    input  wire logic [PEGP_WIDTH-2:0]  timer_drive,
    output logic      [PEGP_WIDTH-1:0]  timer_pin_level
);

    function automatic logic reg_hit(
        input logic [PEGP_ADDR_W-1:0] addr,
        input logic [PEGP_ADDR_W-1:0] ofs
    );
        reg_hit = (addr == ofs);
    endfunction

    pegp_apb_state_t             state_reg;

    logic [PEGP_WIDTH-1:0]       dir_reg;
    logic [PEGP_WIDTH-1:0]       out_reg;
    pegp_bit7_cfg_t              cfg_reg;

    logic [PEGP_WIDTH-1:0]       pin_meta_reg;
    logic [PEGP_WIDTH-1:0]       pin_sync_reg;

    logic [PEGP_WIDTH-1:0]       own_reg;
    logic [PEGP_WIDTH-1:0]       level_reg;
    logic [PEGP_WIDTH-1:0]       oe_n_reg;

    logic [31:0]                 prdata_reg;
    logic                        pready_reg;
    logic                        pslverr_reg;

    logic                        bit7_timer;
    logic [PEGP_WIDTH-1:0]       own_next;
    logic [PEGP_WIDTH-1:0]       out_view;
    logic [31:0]                 rdata_next;
    logic                        addr_ok;
    logic                        commit;
    logic                        wr_commit;

    // Bit 7 ownership decoded from the timer configuration register.
    pegp_bit7_sel u_bit7_sel (
        .cfg        (cfg_reg),
        .timer_owns (bit7_timer)
    );

    // Bits 6 to 0 are owned by the timer when it requests the pin.
    always_comb begin
        own_next = {bit7_timer, timer_drive};
    end

    // Transfer completes at the edge where the master sees pready high.
    always_comb begin
        commit    = (state_reg == PEGP_ST_RESP) && psel && penable;
        wr_commit = commit && pwrite;
    end

    always_comb begin
        addr_ok = reg_hit(paddr, PEGP_OFS_DIR)
               || reg_hit(paddr, PEGP_OFS_OUT)
               || reg_hit(paddr, PEGP_OFS_CFG)
               || reg_hit(paddr, PEGP_OFS_STAT);
    end

    // Output data readback mixes stored and live values per direction bit.
    always_comb begin
        out_view = (out_reg & dir_reg)
                 | (pin_sync_reg & ~dir_reg);
    end

    // Read data mux. The direction register is write-only and reads zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_hit(paddr, PEGP_OFS_OUT)) begin
            rdata_next[PEGP_WIDTH-1:0] = out_view;
        end else if (reg_hit(paddr, PEGP_OFS_CFG)) begin
            rdata_next[PEGP_CFG_DIS_BIT:0] = cfg_reg;
        end else if (reg_hit(paddr, PEGP_OFS_STAT)) begin
            rdata_next[PEGP_STAT_PIN_LSB +: PEGP_WIDTH] = pin_sync_reg;
            rdata_next[PEGP_STAT_OWN_LSB +: PEGP_WIDTH] = own_reg;
        end
    end

    // APB handshake: pready rises one cycle into the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= PEGP_ST_IDLE;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                PEGP_ST_IDLE: begin
                    if (psel && penable) begin
                        state_reg   <= PEGP_ST_RESP;
                        pready_reg  <= 1'b1;
                        pslverr_reg <= !addr_ok;
                        if (!pwrite && addr_ok) begin
                            prdata_reg <= rdata_next;
                        end else begin
                            prdata_reg <= 32'h0000_0000;
                        end
                    end
                end
                PEGP_ST_RESP: begin
                    state_reg   <= PEGP_ST_IDLE;
                    pready_reg  <= 1'b0;
                    pslverr_reg <= 1'b0;
                    prdata_reg  <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Direction register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= PEGP_DIR_RST;
        end else if (wr_commit && reg_hit(paddr, PEGP_OFS_DIR)
                     && pstrb[PEGP_LANE0]) begin
            dir_reg <= pwdata[PEGP_WIDTH-1:0];
        end
    end

    // Output data register keeps the written value whatever the direction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= PEGP_OUT_RST;
        end else if (wr_commit && reg_hit(paddr, PEGP_OFS_OUT)
                     && pstrb[PEGP_LANE0]) begin
            out_reg <= pwdata[PEGP_WIDTH-1:0];
        end
    end

    // Bit 7 timer configuration register, written per byte lane.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= pegp_bit7_cfg_t'(PEGP_CFG_RST);
        end else if (wr_commit && reg_hit(paddr, PEGP_OFS_CFG)) begin
            if (pstrb[PEGP_LANE0]) begin
                cfg_reg[PEGP_CFG_LANE0_MSB:0] <= pwdata[PEGP_CFG_LANE0_MSB:0];
            end
            if (pstrb[PEGP_LANE1]) begin
                cfg_reg[PEGP_CFG_DIS_BIT] <= pwdata[PEGP_CFG_DIS_BIT];
            end
        end
    end

    // Two-stage synchroniser; only the second stage feeds any logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Timer capture always sees the pin, as input channels share it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_pin_level <= '0;
        end else begin
            timer_pin_level <= pin_sync_reg;
        end
    end

    // Pin drivers: timer ownership first, then general I/O direction.
    genvar gi;
    generate
        for (gi = 0; gi < PEGP_WIDTH; gi++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    own_reg[gi]   <= 1'b0;
                    level_reg[gi] <= 1'b0;
                    oe_n_reg[gi]  <= 1'b1;
                end else begin
                    own_reg[gi] <= own_next[gi];
                    if (own_next[gi]) begin
                        level_reg[gi] <= timer_out[gi];
                        oe_n_reg[gi]  <= 1'b0;
                    end else begin
                        level_reg[gi] <= out_reg[gi];
                        oe_n_reg[gi]  <= !dir_reg[gi];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        pin_drive.level = level_reg;
        pin_drive.oe_n  = oe_n_reg;
        prdata          = prdata_reg;
        pready          = pready_reg;
        pslverr         = pslverr_reg;
    end

endmodule

// ### tb/pegp_properties.sv
// Purpose: Port-level assertions for the port E block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to pegp_top after the module.
`timescale 1ns/1ps
module pegp_properties
    import pegp_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [PEGP_WIDTH-1:0] pin_in,
    input wire pegp_pin_drive_t       pin_drive,
    input wire logic [PEGP_WIDTH-1:0] timer_out,
    input wire logic [PEGP_WIDTH-2:0] timer_drive,
    input wire logic [PEGP_WIDTH-1:0] timer_pin_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    property p_reset_pins;
        $rose(presetn) |-> pin_drive.oe_n == 8'hFF && pin_drive.level == 8'h00;
    endproperty
    property p_timer_oe;
        (timer_drive == 7'h7F) [*4] |-> pin_drive.oe_n[6:0] == 7'h00;
    endproperty
    property p_timer_level;
        (timer_drive == 7'h7F && $stable(timer_out)) [*4] |->
            pin_drive.level[6:0] == timer_out[6:0];
    endproperty
    property p_pin_capture;
        (presetn && $stable(pin_in)) [*4] |-> timer_pin_level == pin_in;
    endproperty
    a_ready_wait:   assert property (p_ready_wait) else $error("late ready");
    a_ready_pulse:  assert property (p_ready_pulse) else $error("long ready");
    a_err_ready:    assert property (p_err_ready) else $error("stray error");
    a_rdata_idle:   assert property (p_rdata_idle) else $error("stray data");
    a_reset_pins:   assert property (p_reset_pins) else $error("pins not input");
    a_timer_oe:     assert property (p_timer_oe) else $error("timer not driving");
    a_timer_level:  assert property (p_timer_level) else $error("timer level");
    a_pin_capture:  assert property (p_pin_capture) else $error("pin capture");
    c_error:        cover property (pslverr);
    c_timer:        cover property ((timer_drive == 7'h7F) [*4]);
    c_own7:         cover property (pin_drive.oe_n[7] == 1'b0);
endmodule
bind pegp_top pegp_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_drive(pin_drive), .timer_out(timer_out),
    .timer_drive(timer_drive), .timer_pin_level(timer_pin_level));

// ### tb/pegp_pin_model.sv
// Purpose: Pins outside the port, with an outside source on released pins.
// Assumes: No pull resistors; the bench supplies released levels.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module pegp_pin_model
    import pegp_pkg::*;
(
    input wire pegp_pin_drive_t drive,
    input wire logic [7:0]      ext_level,
    output logic     [7:0]      pin_level
);
    // A pin shows the block's level only while its enable is low.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = drive.oe_n[i] ? ext_level[i] : drive.level[i];
        end
    end
endmodule

// ### tb/tb_port_e_gpio_with_timer_pins.sv
// Purpose: Register and pin tests of the port E block.
// Assumes: APB answers with one wait state.
// Notes:   Each transfer ends with three idle edges so pin drive settles.
`timescale 1ns/1ps
module tb_port_e_gpio_with_timer_pins
    import pegp_pkg::*;
;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [3:0]      pstrb;
    logic [7:0]      pin_in, timer_out, timer_pin_level, ext_level;
    logic [6:0]      timer_drive;
    pegp_pin_drive_t pin_drive;
    int              mismatches, n_tests;
    logic [9:0]      tab [13] = '{10'h100, 10'h000, 10'h240, 10'h2C0, 10'h230, 10'h020,
                                  10'h22A, 10'h22B, 10'h229, 10'h028, 10'h02C, 10'h00A, 10'h1C0};

    pegp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_drive(pin_drive),
        .timer_out(timer_out), .timer_drive(timer_drive), .timer_pin_level(timer_pin_level));
    pegp_pin_model i_pins (.drive(pin_drive), .ext_level(ext_level), .pin_level(pin_in));

    always #5 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        complete_run();
    end

    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        ext_level = 8'h3C;
        timer_out = 8'h80;
        timer_drive = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // The pin synchroniser needs two edges before a readback shows the pins.
        repeat (2) @(posedge pclk);
        apb(0, PEGP_OFS_OUT, 0, 4'hF);
        check(rd, 32'h3C);
        apb(0, PEGP_OFS_CFG, 0, 4'hF);
        check(rd, 32'h100);
        apb(1, PEGP_OFS_DIR, 32'hF0, 4'hF);
        apb(1, PEGP_OFS_OUT, 32'hA5, 4'hF);
        check({16'h0, pin_drive}, 32'hA50F);
        apb(0, PEGP_OFS_OUT, 0, 4'hF);
        check(rd, 32'hAC);
        apb(1, PEGP_OFS_OUT, 32'h00, 4'h0);
        apb(1, 12'h002, 32'h00, 4'hF);
        check({31'h0, err}, 32'h1);
        apb(0, PEGP_OFS_OUT, 0, 4'hF);
        check(rd, 32'hAC);
        timer_out <= 8'h55;
        timer_drive <= 7'h7F;
        repeat (4) @(posedge pclk);
        check({16'h0, pin_drive}, 32'hD500);
        apb(0, PEGP_OFS_OUT, 0, 4'hF);
        check(rd, 32'hA5);
        timer_drive <= '0;
        timer_out <= 8'h80;
        apb(1, PEGP_OFS_DIR, 32'h00, 4'hF);
        apb(1, PEGP_OFS_OUT, 32'h00, 4'hF);
        foreach (tab[i]) begin
            apb(1, PEGP_OFS_CFG, {23'h0, tab[i][8:0]}, 4'h3);
            apb(0, PEGP_OFS_STAT, 0, 4'hF);
            check({29'h0, rd[15], pin_drive.level[7], pin_drive.oe_n[7]},
                  {29'h0, tab[i][9], tab[i][9], ~tab[i][9]});
        end
        apb(1, PEGP_OFS_DIR, 32'hFF, 4'hF);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, PEGP_OFS_CFG, 0, 4'hF);
        check(rd, 32'h100);
        check({24'h0, pin_drive.oe_n}, 32'hFF);
        complete_run();
    end
endmodule
